// file: verilog/ifp_pkg.sv
// package: constants, opcodes and carrier types of the fetch/execute pipeline
package ifp_pkg;

  // ------------------------------------------------------------------
  // widths and depths
  // ------------------------------------------------------------------
  localparam int PC_W      = 21;  // program counter, byte address
  localparam int DA_W      = 12;  // data memory address
  localparam int IW        = 16;  // one program word
  localparam int SP_W      = 5;   // return-stack pointer
  localparam int STK_DEPTH = 31;  // return-stack entries 1..31

  // ------------------------------------------------------------------
  // reset values and steps
  // ------------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RST   = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;  // one word in bytes
  localparam logic [SP_W-1:0] SP_RST   = 5'h00;       // empty, no entry at 0
  localparam logic [SP_W-1:0] SP_TOP   = 5'h1F;
  localparam logic [SP_W-1:0] SP_ONE   = 5'h01;
  localparam logic [7:0]      BYTE_RST = 8'h00;
  localparam logic [IW-1:0]   WORD_RST = 16'h0000;    // also the plain no-op

  // ------------------------------------------------------------------
  // phase bit positions in the one-hot phase vector
  // ------------------------------------------------------------------
  localparam int PH1 = 0;
  localparam int PH2 = 1;
  localparam int PH3 = 2;
  localparam int PH4 = 3;

  // ------------------------------------------------------------------
  // opcode fields, compared against the top bits of a word
  // ------------------------------------------------------------------
  localparam logic [3:0]  OP_SECOND = 4'hF;      // [15:12] second word tag
  localparam logic [7:0]  OP_GOTO   = 8'hEF;     // [15:8]
  localparam logic [6:0]  OP_CALL   = 7'h76;     // [15:9], bit 8 fast
  localparam logic [9:0]  OP_LDPTR  = 10'h3B8;   // [15:6]
  localparam logic [3:0]  OP_MOVE_FILE_TO_FILE  = 4'hC;      // [15:12]
  localparam logic [4:0]  OP_BRA    = 5'h1A;     // [15:11]
  localparam logic [6:0]  OP_TSTZ   = 7'h33;     // [15:9], bit 8 bank
  localparam logic [5:0]  OP_ADDF   = 6'h09;     // [15:10], d=9 a=8
  localparam logic [14:0] OP_RET    = 15'h0009;  // [15:1], bit 0 fast
  localparam logic [7:0]  OP_RETURN_WITH_LITERAL  = 8'h0C;     // [15:8]
  localparam logic [7:0]  OP_MOVLW  = 8'h0F;     // [15:8]
  localparam logic [14:0] OP_TBLRD  = 15'h0004;  // [15:1], bit 0 post-inc

  // ------------------------------------------------------------------
  // data-side addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] PCL_ADDR  = 8'hF9;  // pc_low_byte in the access bank
  localparam logic [7:0] ACC_SPLIT = 8'h60;  // access bank low/high split
  localparam logic [3:0] BANK_LO   = 4'h0;
  localparam logic [3:0] BANK_HI   = 4'hF;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    IFP_Q1 = 2'b00,
    IFP_Q2 = 2'b01,
    IFP_Q3 = 2'b10,
    IFP_Q4 = 2'b11
  } ifp_phase_e;

  // program memory or table read request
  typedef struct packed {
    logic            rd;
    logic [PC_W-1:0] addr;
  } ifp_pm_req_s;

  // data memory request
  typedef struct packed {
    logic            rd;
    logic            wr;
    logic [DA_W-1:0] addr;
    logic [7:0]      wdata;
  } ifp_dm_req_s;

  // fast shadow set
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] acc;
    logic [3:0] bank;
  } ifp_fast_s;

  // pointer literal load
  typedef struct packed {
    logic            ld;
    logic [1:0]      sel;
    logic [DA_W-1:0] val;
  } ifp_ptr_ld_s;

endpackage

// file: verilog/ifp_phase_gen.sv
// module: divide-by-four quadrature phase generator
`timescale 1ns/10ps
module ifp_phase_gen
  import ifp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // one-hot phase, bit 0 is phase_one
  output logic      [3:0] ph_ff
);

  ifp_phase_e st_ff;   // current quarter
  ifp_phase_e nxt_st;  // next quarter

  // quarters follow in a fixed ring
  always_comb
  begin
    unique case (st_ff)
      IFP_Q1: nxt_st = IFP_Q2;
      IFP_Q2: nxt_st = IFP_Q3;
      IFP_Q3: nxt_st = IFP_Q4;
      IFP_Q4: nxt_st = IFP_Q1;
    endcase
  end

  // reset parks in the last quarter so the first cycle out is phase_one
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_ff <= IFP_Q4;
      ph_ff <= 4'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      ph_ff <= 4'h1 << nxt_st;
    end
  end

endmodule // ifp_phase_gen

// file: verilog/ifp_core.sv
// module: two-stage instruction fetch and execute sequencer
`timescale 1ns/10ps
module ifp_core
  import ifp_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // program memory fetch
  output ifp_pm_req_s          pm_req_ff,
  input  wire logic [IW-1:0]   pm_rdata,
  // data memory
  output ifp_dm_req_s          dm_req_ff,
  input  wire logic [7:0]      dm_rdata,
  // table access
  output ifp_pm_req_s          tbl_req_ff,
  input  wire logic [7:0]      tbl_rdata,
  input  wire logic            tbp_ld,
  input  wire logic [PC_W-1:0] tbp_wdata,
  output logic      [7:0]      table_data_latch_ff,
  // core registers owned elsewhere, and the accumulator kept here
  input  wire logic [7:0]      status_in,
  input  wire logic [3:0]      bank_select_value,
  output logic      [7:0]      accumulator_reg_ff,
  output ifp_fast_s            fast_ff,
  output logic                 fast_rst_ff,
  output ifp_ptr_ld_s          ptr_ld_ff,
  // phases
  output logic      [3:0]      ph_ff
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [PC_W-1:0] pc_ff;                 // next fetch address
  logic [IW-1:0]   ir_ff;                 // instruction_holding_reg
  logic            ir_vld_ff;             // holding reg has a live word
  logic            pair_ff;               // holding reg is a consumed 2nd word
  logic [IW-1:0]   first_ff;              // first word of the running pair
  logic [7:0]      opnd_ff;               // operand read in phase two
  logic [PC_W-1:0] tbp_ff;                // table_byte_pointer
  logic [SP_W-1:0] sp_ff;                 // return-stack pointer
  logic [PC_W-1:0] stack_mem [1:STK_DEPTH];
  ifp_fast_s       shadow_ff;             // one-deep fast shadows

  // ------------------------------------------------------------------
  // phase divider
  // ------------------------------------------------------------------
  // quadrature phase divider
  ifp_phase_gen u_phase (
    .clk   (clk),
    .srst  (srst),
    .ph_ff (ph_ff)
  );

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic            exe;       // a first or single word is executing
  logic            is_goto, is_call, is_ldptr, is_move_file_to_file, is_bra;
  logic            is_tst, is_pcl, is_ret, is_return_with_literal, is_movlw, is_tblrd;
  logic            is_two;    // first word of a pair
  logic [7:0]      ir_lit;    // 8-bit literal field
  logic [PC_W-1:0] pc_back;   // address after the executing word
  logic [PC_W-1:0] bra_off;   // sign-extended word offset in bytes
  logic [PC_W-1:0] abs_tgt;   // absolute target from both words
  logic [7:0]      pcl_sum;   // computed-jump low byte
  logic [DA_W-1:0] f_addr;    // banked or access-mapped file address

  // a bubble or a consumed second word does nothing here
  assign exe      = ir_vld_ff & ~pair_ff;
  assign ir_lit   = ir_ff[7:0];
  assign is_goto  = ir_ff[15:8] == OP_GOTO;
  assign is_call  = ir_ff[15:9] == OP_CALL;
  assign is_ldptr = ir_ff[15:6] == OP_LDPTR;
  assign is_move_file_to_file = ir_ff[15:12] == OP_MOVE_FILE_TO_FILE;
  assign is_bra   = ir_ff[15:11] == OP_BRA;
  assign is_tst   = ir_ff[15:9] == OP_TSTZ;
  assign is_ret   = ir_ff[15:1] == OP_RET;
  assign is_return_with_literal = ir_ff[15:8] == OP_RETURN_WITH_LITERAL;
  assign is_movlw = ir_ff[15:8] == OP_MOVLW;
  assign is_tblrd = ir_ff[15:1] == OP_TBLRD;
  // only the destination form aimed at pc_low_byte is a computed jump
  assign is_pcl   = (ir_ff[15:10] == OP_ADDF) & ir_ff[9] & ~ir_ff[8]
                  & (ir_lit == PCL_ADDR);
  assign is_two   = is_goto | is_call | is_move_file_to_file | is_ldptr;

  // pc already stepped twice since this word was fetched
  assign pc_back  = pc_ff - PC_STEP;
  // offset counts words, shifted to bytes
  assign bra_off  = {{9{ir_ff[10]}}, ir_ff[10:0], 1'b0};
  // second word gives its low twelve bits
  assign abs_tgt  = {pm_rdata[11:0], ir_lit, 1'b0};
  // accumulator added to pc low byte
  assign pcl_sum  = pc_back[7:0] + accumulator_reg_ff;
  // access bit clear maps addresses below 60 to bank 0, 60 and up to bank 15
  assign f_addr   = ir_ff[8] ? {bank_select_value, ir_lit}
                  : {(ir_lit < ACC_SPLIT) ? BANK_LO : BANK_HI, ir_lit};

  // ------------------------------------------------------------------
  // flow change, decided in phase four
  // ------------------------------------------------------------------
  logic            jump_w;    // load pc with target
  logic            flush_w;   // discard the word fetched this cycle
  logic            push_w;    // call pushes return address
  logic            pop_w;     // return pops
  logic [PC_W-1:0] target_w;  // new fetch address

  always_comb
  begin
    jump_w   = 1'b0;
    flush_w  = 1'b0;
    push_w   = 1'b0;
    pop_w    = 1'b0;
    target_w = pc_ff;
    if (exe && ph_ff[PH4])
    begin
      if (is_goto || is_call)
      begin
        // second word is on the bus now, so no flush: it enters as consumed
        jump_w   = 1'b1;
        push_w   = is_call;
        target_w = abs_tgt;
      end
      else if (is_bra)
      begin
        jump_w   = 1'b1;
        flush_w  = 1'b1;
        target_w = pc_back + bra_off;
      end
      else if (is_pcl)
      begin
        // odd offsets are not honoured, lsb is forced clear
        jump_w   = 1'b1;
        flush_w  = 1'b1;
        target_w = {pc_back[PC_W-1:8], pcl_sum[7:1], 1'b0};
      end
      else if (is_ret || is_return_with_literal)
      begin
        // an empty stack returns zero, the reset address
        jump_w   = 1'b1;
        flush_w  = 1'b1;
        pop_w    = 1'b1;
        target_w = (sp_ff == SP_RST) ? PC_RST : stack_mem[sp_ff];
      end
      else if (is_tst && (opnd_ff == BYTE_RST))
      begin
        // skipped word becomes a bubble, never a pair head
        flush_w  = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // program counter and fetch
  // ------------------------------------------------------------------
  // pc steps at the end of phase one
  // steps by two, targets keep lsb clear
  always_ff @(posedge clk)
  begin
    if (srst)
      pc_ff <= PC_RST;
    else if (ph_ff[PH1])
      pc_ff <= pc_ff + PC_STEP;
    else if (jump_w)
      pc_ff <= target_w;
  end

  // fetch issued in phase one, once every four clocks, while the previous word executes
  always_ff @(posedge clk)
  begin
    if (srst)
      pm_req_ff <= '0;
    else if (ph_ff[PH1])
    begin
      pm_req_ff.rd   <= 1'b1;
      pm_req_ff.addr <= pc_ff;
    end
    else
      pm_req_ff.rd <= 1'b0;
  end

  // ------------------------------------------------------------------
  // holding register and pair tracking
  // ------------------------------------------------------------------
  // word latched at the end of phase four
  // empty after reset, first cycle only fetches
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ir_ff     <= WORD_RST;
      ir_vld_ff <= 1'b0;
      pair_ff   <= 1'b0;
      first_ff  <= WORD_RST;
    end
    else if (ph_ff[PH4])
    begin
      ir_ff     <= pm_rdata;
      // a flushed word executes as a bubble
      ir_vld_ff <= ~flush_w;
      // a two-word head marks the next word as its data
      // only a word right after its head is consumed
      pair_ff   <= exe & is_two;
      first_ff  <= ir_ff;
    end
  end

  // ------------------------------------------------------------------
  // data memory side
  // ------------------------------------------------------------------
  // read visible in phase two, write in phase four
  always_ff @(posedge clk)
  begin
    if (srst)
      dm_req_ff <= '0;
    else if (ph_ff[PH1] && exe && (is_move_file_to_file || is_tst))
    begin
      dm_req_ff.rd   <= 1'b1;
      dm_req_ff.addr <= is_move_file_to_file ? ir_ff[DA_W-1:0] : f_addr;
    end
    else if (ph_ff[PH3] && pair_ff && ir_vld_ff
             && (first_ff[15:12] == OP_MOVE_FILE_TO_FILE))
    begin
      // destination comes from the consumed second word
      dm_req_ff.wr    <= 1'b1;
      dm_req_ff.addr  <= ir_ff[DA_W-1:0];
      dm_req_ff.wdata <= opnd_ff;
    end
    else
    begin
      dm_req_ff.rd <= 1'b0;
      dm_req_ff.wr <= 1'b0;
    end
  end

  // operand taken at the end of phase three
  always_ff @(posedge clk)
  begin
    if (srst)
      opnd_ff <= BYTE_RST;
    else if (ph_ff[PH3] && exe && (is_move_file_to_file || is_tst))
      opnd_ff <= dm_rdata;
  end

  // ------------------------------------------------------------------
  // table access
  // ------------------------------------------------------------------
  // one byte per read, pointer to latch
  always_ff @(posedge clk)
  begin
    if (srst)
      tbl_req_ff <= '0;
    else if (ph_ff[PH1] && exe && is_tblrd)
    begin
      tbl_req_ff.rd   <= 1'b1;
      tbl_req_ff.addr <= tbp_ff;
    end
    else
      tbl_req_ff.rd <= 1'b0;
  end

  // latch filled at the end of phase three
  always_ff @(posedge clk)
  begin
    if (srst)
      table_data_latch_ff <= BYTE_RST;
    else if (ph_ff[PH3] && exe && is_tblrd)
      table_data_latch_ff <= tbl_rdata;
  end

  // software load beats the post-increment if both land together
  always_ff @(posedge clk)
  begin
    if (srst)
      tbp_ff <= PC_RST;
    else if (tbp_ld)
      tbp_ff <= tbp_wdata;
    else if (ph_ff[PH3] && exe && is_tblrd && ir_ff[0])
      tbp_ff <= tbp_ff + {{(PC_W-1){1'b0}}, 1'b1};
  end

  // ------------------------------------------------------------------
  // accumulator, shadows, pointer load
  // ------------------------------------------------------------------
  // return with literal loads the accumulator
  // fast return restores the saved accumulator
  always_ff @(posedge clk)
  begin
    if (srst)
      accumulator_reg_ff <= BYTE_RST;
    else if (exe && ph_ff[PH4] && (is_movlw || is_return_with_literal))
      accumulator_reg_ff <= ir_lit;
    else if (exe && ph_ff[PH4] && is_ret && ir_ff[0])
      accumulator_reg_ff <= shadow_ff.acc;
  end

  // fast call saves, fast return drives the restore
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shadow_ff   <= '0;
      fast_ff     <= '0;
      fast_rst_ff <= 1'b0;
    end
    else
    begin
      fast_rst_ff <= 1'b0;
      if (push_w && ir_ff[8])
        shadow_ff <= '{status_in, accumulator_reg_ff, bank_select_value};
      if (pop_w && is_ret && ir_ff[0])
      begin
        fast_ff     <= shadow_ff;
        fast_rst_ff <= 1'b1;
      end
    end
  end

  // pointer literal load completes on its consumed second word
  always_ff @(posedge clk)
  begin
    if (srst)
      ptr_ld_ff <= '0;
    else if (ph_ff[PH4] && pair_ff && ir_vld_ff
             && (first_ff[15:6] == OP_LDPTR))
      ptr_ld_ff <= '{1'b1, first_ff[5:4], {first_ff[3:0], ir_lit}};
    else
      ptr_ld_ff.ld <= 1'b0;
  end

  // ------------------------------------------------------------------
  // return stack
  // ------------------------------------------------------------------
  // pointer steps and the new top is written at the same edge
  always_ff @(posedge clk)
  begin
    if (srst)
      sp_ff <= SP_RST;
    else if (push_w && (sp_ff != SP_TOP))
      sp_ff <= sp_ff + SP_ONE;
    else if (pop_w && (sp_ff != SP_RST))
      sp_ff <= sp_ff - SP_ONE;
  end

  // return address is pc after the second call word; full stack drops it
  always_ff @(posedge clk)
  begin
    if (push_w && (sp_ff != SP_TOP))
      stack_mem[sp_ff + SP_ONE] <= pc_ff;
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_phase_ring: assert property (
    ph_ff[PH1] |=> ph_ff[PH2] ##1 ph_ff[PH3] ##1 ph_ff[PH4] ##1 ph_ff[PH1]
  ) else $error("phase ring broken");

  a_pc_step: assert property (
    ph_ff[PH1] |=> pc_ff == $past(pc_ff) + PC_STEP
  ) else $error("pc did not step by two in phase one");

  a_pc_even: assert property (
    !pc_ff[0] && !pm_req_ff.addr[0]
  ) else $error("odd program address");

  a_ir_latch: assert property (
    ph_ff[PH4] |=> ir_ff == $past(pm_rdata)
  ) else $error("fetched word not latched in phase four");

  a_dm_phases: assert property (
    (dm_req_ff.rd |-> ph_ff[PH2]) and (dm_req_ff.wr |-> ph_ff[PH4])
  ) else $error("data access in wrong phase");

  a_flush_two: assert property (
    (ph_ff[PH4] && flush_w) |=> !ir_vld_ff [*4] ##1 ir_vld_ff
  ) else $error("flush did not give one bubble cycle");

  a_goto_target: assert property (
    (ph_ff[PH4] && exe && is_goto) |=> pc_ff == $past(abs_tgt) ##1
    pm_req_ff.addr == $past(abs_tgt, 2)
  ) else $error("absolute target not fetched");

  a_call_push: assert property (
    (push_w && sp_ff != SP_TOP) |=>
    sp_ff == $past(sp_ff) + SP_ONE && stack_mem[sp_ff] == $past(pc_ff)
  ) else $error("call push order wrong");

  a_lone_nop: assert property (
    (ph_ff[PH4] && ir_vld_ff && !pair_ff && ir_ff[15:12] == OP_SECOND)
    |-> !jump_w && !flush_w ##1 !ptr_ld_ff.ld && !dm_req_ff.wr
  ) else $error("lone second word was not a no-op");

  a_return_with_literal_acc: assert property (
    (ph_ff[PH4] && exe && is_return_with_literal) |=> accumulator_reg_ff == $past(ir_lit)
  ) else $error("literal not returned in accumulator");

  a_reset_empty: assert property (disable iff (1'b0)
    srst |=> pc_ff == PC_RST && !ir_vld_ff && !pm_req_ff.rd
  ) else $error("pipeline not empty after reset");

  c_goto: cover property (ph_ff[PH4] && exe && is_goto);
  c_skip_pair: cover property (
    ph_ff[PH4] && flush_w && is_tst ##4 ph_ff[PH4] && !ir_vld_ff);
  c_return_with_literal: cover property (ph_ff[PH4] && exe && is_return_with_literal);
  c_move_file_to_file: cover property (dm_req_ff.wr);

endmodule // ifp_core

// file: dv/ifp_mem_model.sv
// partner model: program and data memory arrays behind the core, table reads served from the program array
`timescale 1ns/10ps
module ifp_mem_model
  import ifp_pkg::*;
(
  // clock
  input  wire logic        clk,
  // requests from the core
  input  wire ifp_pm_req_s pm_req,
  input  wire ifp_dm_req_s dm_req,
  input  wire ifp_pm_req_s tbl_req,
  // answers to the core
  output logic [IW-1:0]    pm_rdata,
  output logic [7:0]       dm_rdata,
  output logic [7:0]       tbl_rdata
);
  logic [IW-1:0] prog [0:255];  // program words, loaded by the bench
  logic [7:0]    dmem [0:255];  // data bytes, low address bits only
  logic [IW-1:0] pw;            // captured program word
  logic [7:0]    dw;            // captured data byte
  logic [7:0]    tw;            // captured table byte
  int            pc_n = 0;      // cycles the program word stays valid
  int            dc_n = 0;      // cycles the data byte stays valid
  int            tc_n = 0;      // cycles the table byte stays valid

  // ------------------------------------------------------------------
  // capture on each request pulse, then count the valid window down
  // ------------------------------------------------------------------
  always @(posedge clk)
  begin
    pc_n <= (pm_req.rd) ? 2 : ((pc_n > 0) ? pc_n - 1 : 0);
    dc_n <= (dm_req.rd) ? 1 : 0;
    tc_n <= (tbl_req.rd) ? 1 : 0;
    if (pm_req.rd)
      pw <= prog[pm_req.addr[8:1]];
    if (dm_req.rd)
      dw <= dmem[dm_req.addr[7:0]];
    if (dm_req.wr)
      dmem[dm_req.addr[7:0]] <= dm_req.wdata;
    // odd table address picks the high byte of the word
    if (tbl_req.rd)
      tw <= tbl_req.addr[0] ? prog[tbl_req.addr[8:1]][15:8] : prog[tbl_req.addr[8:1]][7:0];
  end

  // outside the window the lines show an inverse pattern, so a late
  // sample in the core cannot pass on a stale word by luck
  assign pm_rdata  = (pc_n > 0) ? pw : ~pw;
  assign dm_rdata  = (dc_n > 0) ? dw : ~dw;
  assign tbl_rdata = (tc_n > 0) ? tw : ~tw;
endmodule // ifp_mem_model

// file: dv/tb_top.sv
// testbench: runs a short program and compares fetches and accumulator
`timescale 1ns/10ps
module tb_top;
  import ifp_pkg::*;
  logic        clk = 1'b0;      // 100 MHz core clock
  logic        srst = 1'b1;     // synchronous reset
  logic        tbp_ld = 1'b0;   // random pointer loads
  logic [20:0] tbp_wdata = '0;  // random pointer value
  logic [7:0]  status_in = '0;  // random status
  logic [3:0]  bank_select_value = '0;  // random bank
  ifp_pm_req_s pm_req_ff, tbl_req_ff;  // fetch and table requests
  ifp_dm_req_s dm_req_ff;       // data requests
  logic [15:0] pm_rdata;        // program word
  logic [7:0]  dm_rdata, tbl_rdata, acc;  // bytes back and accumulator
  logic [3:0]  ph_ff;           // phases
  int          n_fail = 0;      // mismatches
  int          n_checks = 0;    // comparisons
  int          exp_q[$];        // model: expected fetch addresses
  int          acc_at[int];     // model: accumulator at given fetches
  int          a;               // current expected address

  // ------------------------------------------------------------------
  // clock, design and partner
  // ------------------------------------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end
  ifp_core dut_u (.clk(clk), .srst(srst), .pm_req_ff(pm_req_ff), .pm_rdata(pm_rdata),
    .dm_req_ff(dm_req_ff), .dm_rdata(dm_rdata), .tbl_req_ff(tbl_req_ff),
    .tbl_rdata(tbl_rdata), .tbp_ld(tbp_ld), .tbp_wdata(tbp_wdata),
    .table_data_latch_ff(), .status_in(status_in), .bank_select_value(bank_select_value),
    .accumulator_reg_ff(acc), .fast_ff(), .fast_rst_ff(), .ptr_ld_ff(), .ph_ff(ph_ff));
  ifp_mem_model pmod_u (.clk(clk), .pm_req(pm_req_ff), .dm_req(dm_req_ff),
    .tbl_req(tbl_req_ff), .pm_rdata(pm_rdata), .dm_rdata(dm_rdata), .tbl_rdata(tbl_rdata));

  // ------------------------------------------------------------------
  // compare, verdict and watchdog
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // whole program needs about 100 cycles; this margin only cuts hangs
  initial
  begin
    repeat (3000) @(posedge clk);
    chk("watchdog", 0, 1);
    tally_and_finish;
  end

  // random side inputs change at the falling edge only
  always @(negedge clk)
  begin
    status_in = 8'($urandom);
    bank_select_value = 4'($urandom);
    tbp_ld = 1'($urandom);
    tbp_wdata = 21'($urandom);
  end

  // ------------------------------------------------------------------
  // each fetch pulse: phase, address and accumulator against the model
  // ------------------------------------------------------------------
  always @(negedge clk)
  begin
    if (!srst && pm_req_ff.rd === 1'b1 && exp_q.size() > 0)
    begin
      a = exp_q.pop_front();
      chk("fetch_phase", 32'h2, 32'(ph_ff));
      chk("fetch_addr", 32'(a), 32'(pm_req_ff.addr));
      if (acc_at.exists(a))
        chk("acc", 32'(acc_at[a]), 32'(acc));
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hA4557DC7));
    // lone second words everywhere act as no-ops
    for (int i = 0; i < 256; i++)
      pmod_u.prog[i] = 16'hF000;
    pmod_u.prog[8'h00] = 16'h0F5A;  // load 5A
    pmod_u.prog[8'h01] = 16'hEF10;  // jump to 20, two words
    pmod_u.prog[8'h10] = 16'hD002;  // branch two words ahead to 26
    pmod_u.prog[8'h11] = 16'h0F77;  // flushed, never executed
    pmod_u.prog[8'h13] = 16'hF123;  // lone second word
    pmod_u.prog[8'h14] = 16'h0F04;  // even table offset
    pmod_u.prog[8'h15] = 16'hEC20;  // call 40, two words
    pmod_u.prog[8'h17] = 16'h0F99;  // after return
    pmod_u.prog[8'h18] = 16'h6600;  // test 000, zero: skip next
    pmod_u.prog[8'h19] = 16'hC001;  // skipped move head
    pmod_u.prog[8'h1A] = 16'hF002;  // its second word runs as a no-op
    pmod_u.prog[8'h1B] = 16'h6601;  // test 001, nonzero: no skip
    pmod_u.prog[8'h1C] = 16'hC001;  // move 001 to 003
    pmod_u.prog[8'h1D] = 16'hF003;
    pmod_u.prog[8'h1E] = 16'hD7FF;  // branch to itself
    pmod_u.dmem[0] = 8'h00;
    pmod_u.dmem[1] = 8'h5C;
    pmod_u.dmem[2] = 8'hEE;
    pmod_u.prog[8'h20] = 16'h26F9;  // computed jump by accumulator
    pmod_u.prog[8'h21] = 16'h0C11;
    pmod_u.prog[8'h22] = 16'h0C22;
    pmod_u.prog[8'h23] = 16'h0C33;
    exp_q = '{'h00, 'h02, 'h04, 'h20, 'h22, 'h26, 'h28, 'h2A, 'h2C,
              'h40, 'h42, 'h46, 'h48, 'h2E, 'h30, 'h32, 'h34, 'h36, 'h38,
              'h3A, 'h3C, 'h3E, 'h3C, 'h3E};
    acc_at['h20] = 'h5A;
    acc_at['h42] = 'h04;
    acc_at['h2E] = 'h33;
    repeat (5) @(negedge clk);
    chk("ph_reset", 0, 32'(ph_ff));
    srst = 1'b0;
    for (int i = 0; i < 400 && exp_q.size() > 0; i++)
      @(negedge clk);
    chk("fetches_left", 0, 32'(exp_q.size()));
    chk("acc_end", 32'h99, 32'(acc));
    chk("dm_move", 32'h5C, 32'(pmod_u.dmem[3]));
    chk("dm_skipped", 32'hEE, 32'(pmod_u.dmem[2]));
    tally_and_finish;
  end
endmodule // tb_top
